// File: dv/comparator_output_irq_mux_checker.sv
/*
 * Port checker for the comparator output and interrupt block: raw and
 * synchronised paths, register read path, mux decode, interrupt gating.
 * Assumes it is bound to every instance of comparator_output_irq_mux.
 */
`timescale 1ns/10ps
`default_nettype none

`include "comparator_params.svh"

module comparator_output_irq_mux_checker #(
   parameter int SYNC_STAGES = 2
) (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   input wire logic        cmp_analog_gt,
   input wire logic        global_irq_enable,
   input wire logic        cmp_enable,
   input wire logic [11:0] pos_mux_enable,
   input wire logic [10:0] neg_mux_enable,
   input wire logic        cmp_zero_sync_out,
   input wire logic        cmp_zero_raw_out,
   input wire logic        irq_request
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   logic [7:0] sel_copy;
   logic [7:0] next_sel_copy;
   logic [1:0] up_cnt;
   logic [1:0] next_up_cnt;

   function automatic logic [11:0] pos_dec(input logic [7:0] s);
      if (s[3:0] < 4'h8) return 12'h001 << s[3:0];
      return (s[3:0] > 4'hB) ? 12'h001 << (s[3:0] - 4'h4) : 12'h000;
   endfunction

   function automatic logic [10:0] neg_dec(input logic [7:0] s);
      if (s[7:4] < 4'h7) return 11'h001 << s[7:4];
      return (s[7:4] > 4'hB) ? 11'h001 << (s[7:4] - 4'h5) : 11'h000;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // shadow of the select register; counter masks the pipeline fill
   always_comb begin
      next_sel_copy = sel_copy;
      next_up_cnt = (up_cnt == 2'd3) ? up_cnt : up_cnt + 2'd1;
      if (reg_write && reg_addr == `CMP_INPUT_SELECT_ADDR) next_sel_copy = reg_wdata;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sel_copy <= 8'hFF;
         up_cnt   <= 2'd0;
      end else begin
         sel_copy <= next_sel_copy;
         up_cnt   <= next_up_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_raw_gated: assert property (cmp_zero_raw_out == (cmp_enable & cmp_analog_gt))
      else $error("raw output differs from enable and decision");
   a_sync_delay: assert property (up_cnt == 2'd3 |->
      cmp_zero_sync_out == $past(cmp_zero_raw_out, SYNC_STAGES))
      else $error("synchronised output does not trail the raw output");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data not idle outside the read answer");
   a_sel_readback: assert property (reg_read && reg_addr == `CMP_INPUT_SELECT_ADDR
      |=> reg_rdata == $past(sel_copy))
      else $error("select register read back wrong");
   a_pos_decode: assert property (up_cnt == 2'd3 |-> pos_mux_enable == pos_dec($past(sel_copy)))
      else $error("positive mux enable wrong");
   a_neg_decode: assert property (up_cnt == 2'd3 |-> neg_mux_enable == neg_dec($past(sel_copy)))
      else $error("negative mux enable wrong");
   a_enable_write: assert property (reg_write && reg_addr == `CMP_MODE_ADDR
      |=> cmp_enable == $past(reg_wdata[7]))
      else $error("comparator enable not taken from mode write");
   a_irq_global: assert property (irq_request |-> $past(global_irq_enable))
      else $error("request without global enable");
   a_irq_src_off: assert property (reg_write && reg_addr == `CMP_MODE_ADDR && !reg_wdata[0]
      |=> ##1 !irq_request)
      else $error("request without source enable");

   c_irq_rise: cover property ($rose(irq_request));
   c_sync_rise: cover property ($rose(cmp_zero_sync_out));
   c_sync_fall: cover property ($fell(cmp_zero_sync_out));
   c_flag_clear: cover property (reg_write && reg_addr == `CMP_STATUS_ADDR);
endmodule // comparator_output_irq_mux_checker

bind comparator_output_irq_mux comparator_output_irq_mux_checker #(
   .SYNC_STAGES(SYNC_STAGES)
) u_checker (
   .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .cmp_analog_gt(cmp_analog_gt), .global_irq_enable(global_irq_enable),
   .cmp_enable(cmp_enable), .pos_mux_enable(pos_mux_enable),
   .neg_mux_enable(neg_mux_enable), .cmp_zero_sync_out(cmp_zero_sync_out),
   .cmp_zero_raw_out(cmp_zero_raw_out), .irq_request(irq_request)
);

`default_nettype wire

// File: dv/comparator_output_irq_mux_tb_top.sv
/*
 * Self-checking bench of the comparator output and interrupt block with
 * a register, flag and interrupt model in the bench.
 * Assumes the checker file is compiled alongside for the bind.
 */
`timescale 1ns/10ps
`default_nettype none

`include "comparator_params.svh"

module comparator_output_irq_mux_tb_top;
   logic        ref_clk;
   logic        resetn;
   logic [7:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_write;
   logic        reg_read;
   logic [7:0]  reg_rdata;
   logic        cmp_analog_gt;
   logic        global_irq_enable;
   logic        cmp_enable;
   logic [11:0] pos_mux_enable;
   logic [10:0] neg_mux_enable;
   logic        cmp_zero_sync_out;
   logic        cmp_zero_raw_out;
   logic        irq_request;
   int          n_mismatch;
   int          comparisons;
   logic [7:0]  lfsr;
   logic [7:0]  m_sel;
   logic [7:0]  m_mode;
   logic        m_res;
   logic        m_rise;
   logic        m_fall;

   comparator_output_irq_mux #(.SYNC_STAGES(2)) dut (
      .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .cmp_analog_gt(cmp_analog_gt), .global_irq_enable(global_irq_enable),
      .cmp_enable(cmp_enable), .pos_mux_enable(pos_mux_enable),
      .neg_mux_enable(neg_mux_enable), .cmp_zero_sync_out(cmp_zero_sync_out),
      .cmp_zero_raw_out(cmp_zero_raw_out), .irq_request(irq_request)
   );

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction

   function automatic logic [11:0] pos_dec(input logic [3:0] c);
      if (c < 4'h8) return 12'h001 << c;
      return (c > 4'hB) ? 12'h001 << (c - 4'h4) : 12'h000;
   endfunction

   function automatic logic [11:0] neg_dec(input logic [3:0] c);
      if (c < 4'h7) return 12'h001 << c;
      return (c > 4'hB) ? 12'h001 << (c - 4'h5) : 12'h000;
   endfunction

   task check(input string name, input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // bus tasks; the model follows every write
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      if (a == `CMP_INPUT_SELECT_ADDR) m_sel = d;
      if (a == `CMP_MODE_ADDR) m_mode = d;
      if (a == `CMP_STATUS_ADDR) m_rise &= d[5];
      if (a == `CMP_STATUS_ADDR) m_fall &= d[4];
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check("reg_rdata", {4'h0, reg_rdata}, {4'h0, exp});
   endtask

   // four edges cover sync, flag and request latency
   task apply();
      logic r;
      settle(4);
      r = cmp_analog_gt & m_mode[7];
      if (r & !m_res) m_rise = 1'b1;
      if (!r & m_res) m_fall = 1'b1;
      m_res = r;
      check("cmp_enable", {11'h0, cmp_enable}, {11'h0, m_mode[7]});
      check("sync_out", {11'h0, cmp_zero_sync_out}, {11'h0, m_res});
      check("raw_out", {11'h0, cmp_zero_raw_out}, {11'h0, r});
      check("irq_request", {11'h0, irq_request}, {11'h0, ((m_rise & m_mode[5]) |
         (m_fall & m_mode[4])) & m_mode[0] & global_irq_enable});
      rd(`CMP_STATUS_ADDR, {1'b0, m_res, m_rise, m_fall, 4'h0});
   endtask

   task set_in(input logic g, input logic e);
      @(posedge ref_clk);
      cmp_analog_gt     <= g;
      global_irq_enable <= e;
      apply();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog against a hung handshake
   initial begin
      repeat (4000) @(posedge ref_clk);
      n_mismatch++;
      print_verdict();
   end

   // main sequence
   initial begin
      ref_clk = 1'b0;
      resetn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
      cmp_analog_gt = 1'b0;
      global_irq_enable = 1'b0;
      n_mismatch = 0;
      comparisons = 0;
      lfsr = 8'h56;
      m_sel = 8'hFF;
      m_mode = 8'h00;
      {m_res, m_rise, m_fall} = 3'b000;
      repeat (8) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`CMP_MODE_ADDR, 8'h00);
      rd(8'h55, 8'h00);
      // all select codes, then random ones
      for (int i = 0; i < 22; i++) begin
         rd(`CMP_INPUT_SELECT_ADDR, m_sel);
         check("pos_mux", pos_mux_enable, pos_dec(m_sel[3:0]));
         check("neg_mux", {1'b0, neg_mux_enable}, neg_dec(m_sel[7:4]));
         wr(`CMP_INPUT_SELECT_ADDR, (i < 16) ? {4'(15 - i), 4'(i)} : lfsr);
         lfsr = lfsr_next(lfsr);
      end
      wr(8'h55, 8'h00);
      rd(`CMP_INPUT_SELECT_ADDR, m_sel);
      check("pos_mux", pos_mux_enable, pos_dec(m_sel[3:0]));
      check("neg_mux", {1'b0, neg_mux_enable}, neg_dec(m_sel[7:4]));
      set_in(1'b1, 1'b1);
      wr(`CMP_MODE_ADDR, 8'h80);
      apply();
      set_in(1'b0, 1'b1);
      apply();
      wr(`CMP_STATUS_ADDR, 8'hEF);
      apply();
      wr(`CMP_STATUS_ADDR, 8'h00);
      apply();
      wr(`CMP_MODE_ADDR, 8'hB1);
      apply();
      set_in(1'b1, 1'b1);
      set_in(1'b1, 1'b0);
      set_in(1'b1, 1'b1);
      wr(`CMP_MODE_ADDR, 8'h91);
      apply();
      set_in(1'b0, 1'b1);
      wr(`CMP_MODE_ADDR, 8'hB0);
      apply();
      wr(`CMP_MODE_ADDR, 8'hB1);
      apply();
      // random decisions, enables and partial flag clears
      for (int k = 0; k < 10; k++) begin
         set_in(lfsr[0], lfsr[1] | lfsr[2]);
         wr(`CMP_STATUS_ADDR, lfsr);
         apply();
         lfsr = lfsr_next(lfsr);
      end
      // mid-run reset puts back every register and flag
      @(posedge ref_clk);
      resetn <= 1'b0;
      @(posedge ref_clk);
      #1;
      check("rst_pos_mux", pos_mux_enable, 12'h000);
      check("rst_neg_mux", {1'b0, neg_mux_enable}, 12'h000);
      check("rst_irq", {11'h0, irq_request}, 12'h000);
      check("rst_sync", {11'h0, cmp_zero_sync_out}, 12'h000);
      m_sel = 8'hFF;
      m_mode = 8'h00;
      {m_res, m_rise, m_fall} = 3'b000;
      @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`CMP_MODE_ADDR, 8'h00);
      rd(`CMP_STATUS_ADDR, 8'h00);
      rd(`CMP_INPUT_SELECT_ADDR, m_sel);
      wr(`CMP_MODE_ADDR, 8'h00);
      apply();
      print_verdict();
   end
endmodule // comparator_output_irq_mux_tb_top

`default_nettype wire

// File: hdl/cmp_sync_edge.sv
/*
 * Synchroniser and edge detector for the comparator decision.
 * Assumes the input may change at any time with respect to ref_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module cmp_sync_edge #(
   parameter int STAGES = 2
) (
   input  wire logic ref_clk,
   input  wire logic resetn,
   input  wire logic async_in,
   output var  logic sync_out,
   output var  logic rise_pulse,
   output var  logic fall_pulse
);

   // one flop alone cannot settle a metastable sample
   if (STAGES < 2) begin : g_bad_stages
      $error("cmp_sync_edge needs at least two stages");
   end

   logic [STAGES-1:0] stage;
   logic [STAGES-1:0] next_stage;
   logic              prev;
   logic              next_prev;

   ////////////////////////////////////////////////////////////////////////
   // shift chain; only the next stage reads the first flop
   always_comb begin
      next_stage = {stage[STAGES-2:0], async_in};
      next_prev  = stage[STAGES-1];
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stage <= '0;
         prev  <= 1'b0;
      end else begin
         stage <= next_stage;
         prev  <= next_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // consecutive samples compared
   assign sync_out   = stage[STAGES-1];
   assign rise_pulse = stage[STAGES-1] & ~prev;
   assign fall_pulse = ~stage[STAGES-1] & prev;

endmodule // cmp_sync_edge

`default_nettype wire

// File: hdl/comparator_output_irq_mux.sv
/*
 * Digital side of a voltage comparator: input channel select register,
 * analog mux enables, synchronised and raw outputs, edge flags and the
 * interrupt request.
 * Assumes cmp_analog_gt comes from the analog core (high while the
 * selected positive input is above the negative one) and a register port
 * with one-cycle strobes and read data in the following cycle.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

`include "comparator_params.svh"

module comparator_output_irq_mux #(
   parameter int SYNC_STAGES = `CMP_SYNC_STAGES
) (
   input  wire logic                          ref_clk,
   input  wire logic                          resetn,
   input  wire logic [7:0]                    reg_addr,
   input  wire logic [7:0]                    reg_wdata,
   input  wire logic                          reg_write,
   input  wire logic                          reg_read,
   output var  logic [7:0]                    reg_rdata,
   input  wire logic                          cmp_analog_gt,
   input  wire logic                          global_irq_enable,
   output var  logic                          cmp_enable,
   output var  logic [`CMP_POS_MUX_WIDTH-1:0] pos_mux_enable,
   output var  logic [`CMP_NEG_MUX_WIDTH-1:0] neg_mux_enable,
   output var  logic                          cmp_zero_sync_out,
   output var  logic                          cmp_zero_raw_out,
   output var  logic                          irq_request
);

   // refuse a chain too short to let a metastable sample settle
   if (SYNC_STAGES < 2) begin : g_bad_stages
      $error("comparator_output_irq_mux needs SYNC_STAGES of two or more");
   end

   ////////////////////////////////////////////////////////////////////////
   // declarations

   logic [7:0] input_select;
   logic [7:0] next_input_select;
   logic       rise_irq_enable;
   logic       next_rise_irq_enable;
   logic       fall_irq_enable;
   logic       next_fall_irq_enable;
   logic       irq_source_enable;
   logic       next_irq_source_enable;
   logic       next_cmp_enable;
   logic       rise_edge_flag;
   logic       next_rise_edge_flag;
   logic       fall_edge_flag;
   logic       next_fall_edge_flag;
   logic [7:0] next_reg_rdata;
   logic       next_irq_request;
   logic [`CMP_POS_MUX_WIDTH-1:0] next_pos_mux_enable;
   logic [`CMP_NEG_MUX_WIDTH-1:0] next_neg_mux_enable;
   logic       gated_decision;
   logic       sync_level;
   logic       rise_pulse;
   logic       fall_pulse;
   logic       cmp_result_status;
   logic       wr_select;
   logic       wr_mode;
   logic       wr_status;
   logic [3:0] neg_select;
   logic [3:0] pos_select;

   ////////////////////////////////////////////////////////////////////////
   // raw decision path

   // disabled comparator reads low; this path has no flop so it still
   // works with the clock stopped, at the price of being glitchy
   assign gated_decision   = cmp_enable & cmp_analog_gt;
   assign cmp_zero_raw_out = gated_decision;

   // synchroniser and edge detection of the gated decision
   cmp_sync_edge #(
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .async_in   (gated_decision),
      .sync_out   (sync_level),
      .rise_pulse (rise_pulse),
      .fall_pulse (fall_pulse)
   );

   // latched copy serves status, interrupt and port routing
   assign cmp_result_status = sync_level;
   assign cmp_zero_sync_out = sync_level;

   ////////////////////////////////////////////////////////////////////////
   // register write decode

   // one strobe per register; a write to an unmapped
   // address selects nothing and is dropped
   always_comb begin
      wr_select = reg_write && (reg_addr == `CMP_INPUT_SELECT_ADDR);
      wr_mode   = reg_write && (reg_addr == `CMP_MODE_ADDR);
      wr_status = reg_write && (reg_addr == `CMP_STATUS_ADDR);
   end

   // select and mode registers
   always_comb begin
      next_input_select      = input_select;
      next_cmp_enable        = cmp_enable;
      next_rise_irq_enable   = rise_irq_enable;
      next_fall_irq_enable   = fall_irq_enable;
      next_irq_source_enable = irq_source_enable;
      if (wr_select) begin
         next_input_select = reg_wdata;   // reserved codes kept as written
      end
      if (wr_mode) begin
         next_cmp_enable        = reg_wdata[`CMP_MODE_ENABLE_BIT];
         next_rise_irq_enable   = reg_wdata[`CMP_MODE_RISE_IE_BIT];
         next_fall_irq_enable   = reg_wdata[`CMP_MODE_FALL_IE_BIT];
         next_irq_source_enable = reg_wdata[`CMP_MODE_SRC_IE_BIT];
      end
   end

   // reset leaves the comparator off, every switch open and both selects on
   // their top codes, so the first clock after reset closes supply against ground
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         input_select      <= `CMP_INPUT_SELECT_RESET;
         cmp_enable        <= 1'b0;
         rise_irq_enable   <= 1'b0;
         fall_irq_enable   <= 1'b0;
         irq_source_enable <= 1'b0;
      end else begin
         input_select      <= next_input_select;
         cmp_enable        <= next_cmp_enable;
         rise_irq_enable   <= next_rise_irq_enable;
         fall_irq_enable   <= next_fall_irq_enable;
         irq_source_enable <= next_irq_source_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // edge flags

   // writing 0 clears a flag, writing 1 leaves it; an edge in the clearing
   // cycle wins so no event is lost
   always_comb begin
      next_rise_edge_flag = rise_edge_flag;
      next_fall_edge_flag = fall_edge_flag;
      if (wr_status && !reg_wdata[`CMP_STAT_RISE_BIT]) begin
         next_rise_edge_flag = 1'b0;
      end
      if (wr_status && !reg_wdata[`CMP_STAT_FALL_BIT]) begin
         next_fall_edge_flag = 1'b0;
      end
      if (rise_pulse) begin
         next_rise_edge_flag = 1'b1;
      end
      if (fall_pulse) begin
         next_fall_edge_flag = 1'b1;
      end
   end

   // only reset and a written zero ever clear the flags
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rise_edge_flag <= 1'b0;
         fall_edge_flag <= 1'b0;
      end else begin
         rise_edge_flag <= next_rise_edge_flag;
         fall_edge_flag <= next_fall_edge_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt request

   // either edge, or both, depending on the two enables
   always_comb begin
      next_irq_request = ((rise_edge_flag && rise_irq_enable)
                          || (fall_edge_flag && fall_irq_enable))
                         && irq_source_enable && global_irq_enable;
   end

   // registered so the request line never glitches; this costs
   // one cycle of latency after the flag
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= next_irq_request;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // analog mux decode

   // the two nibbles of the select register
   assign neg_select = input_select[`CMP_NEG_SEL_MSB:`CMP_NEG_SEL_LSB];
   assign pos_select = input_select[`CMP_POS_SEL_MSB:`CMP_POS_SEL_LSB];

   // one-hot switch enables; reserved codes close no switch at all
   always_comb begin
      next_neg_mux_enable = '0;
      unique case (comparator_pkg::neg_channel_t'(neg_select))
         comparator_pkg::NEG_PIN_0,
         comparator_pkg::NEG_PIN_1,
         comparator_pkg::NEG_PIN_2,
         comparator_pkg::NEG_PIN_3,
         comparator_pkg::NEG_PIN_4,
         comparator_pkg::NEG_PIN_5,
         comparator_pkg::NEG_PIN_6: begin
            next_neg_mux_enable[neg_select[2:0]] = 1'b1;   // odd pins
         end
         comparator_pkg::NEG_TOUCH:   next_neg_mux_enable[7]  = 1'b1;
         comparator_pkg::NEG_HALF:    next_neg_mux_enable[8]  = 1'b1;
         comparator_pkg::NEG_DIGITAL: next_neg_mux_enable[9]  = 1'b1;
         comparator_pkg::NEG_GROUND:  next_neg_mux_enable[10] = 1'b1;
         default:                     next_neg_mux_enable     = '0;   // reserved
      endcase
   end

   always_comb begin
      next_pos_mux_enable = '0;
      if (pos_select <= comparator_pkg::POS_PIN_7) begin
         next_pos_mux_enable[pos_select[2:0]] = 1'b1;      // even pins
      end else begin
         unique case (comparator_pkg::pos_channel_t'(pos_select))
            comparator_pkg::POS_TOUCH:   next_pos_mux_enable[8]  = 1'b1;
            comparator_pkg::POS_HALF:    next_pos_mux_enable[9]  = 1'b1;
            comparator_pkg::POS_BATTERY: next_pos_mux_enable[10] = 1'b1;
            comparator_pkg::POS_SUPPLY:  next_pos_mux_enable[11] = 1'b1;
            default:                     next_pos_mux_enable     = '0;   // reserved
         endcase
      end
   end

   // registered so the switches never see decode glitches
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         neg_mux_enable <= '0;
         pos_mux_enable <= '0;
      end else begin
         neg_mux_enable <= next_neg_mux_enable;
         pos_mux_enable <= next_pos_mux_enable;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register read

   // data stand for the cycle after the strobe only; unmapped reads zero
   always_comb begin
      next_reg_rdata = `CMP_READ_IDLE;
      if (reg_read) begin
         unique case (reg_addr)
            `CMP_INPUT_SELECT_ADDR: begin
               next_reg_rdata = input_select;
            end
            `CMP_MODE_ADDR: begin
               next_reg_rdata[`CMP_MODE_ENABLE_BIT]  = cmp_enable;
               next_reg_rdata[`CMP_MODE_RISE_IE_BIT] = rise_irq_enable;
               next_reg_rdata[`CMP_MODE_FALL_IE_BIT] = fall_irq_enable;
               next_reg_rdata[`CMP_MODE_SRC_IE_BIT]  = irq_source_enable;
            end
            `CMP_STATUS_ADDR: begin
               next_reg_rdata[`CMP_STAT_RESULT_BIT] = cmp_result_status;
               next_reg_rdata[`CMP_STAT_RISE_BIT]   = rise_edge_flag;
               next_reg_rdata[`CMP_STAT_FALL_BIT]   = fall_edge_flag;
            end
            default: begin
               next_reg_rdata = `CMP_READ_IDLE;
            end
         endcase
      end
   end

   // registered read data; the master takes it in the cycle after
   // its strobe, and the byte reads zero in every other cycle
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= `CMP_READ_IDLE;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule // comparator_output_irq_mux

`default_nettype wire

// File: hdl/comparator_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * comparator output and interrupt block.
 * Assumes an 8-bit register port; included by its bare name.
 */
`ifndef COMPARATOR_PARAMS_SVH
`define COMPARATOR_PARAMS_SVH

// register offsets
`define CMP_INPUT_SELECT_ADDR 8'h9F
`define CMP_MODE_ADDR         8'h9D
`define CMP_STATUS_ADDR       8'h9C

// reset values
`define CMP_INPUT_SELECT_RESET 8'hFF
`define CMP_MODE_RESET         8'h00
`define CMP_READ_IDLE          8'h00

// input select fields
`define CMP_NEG_SEL_MSB 7
`define CMP_NEG_SEL_LSB 4
`define CMP_POS_SEL_MSB 3
`define CMP_POS_SEL_LSB 0

// mode register bits
`define CMP_MODE_ENABLE_BIT   7
`define CMP_MODE_RISE_IE_BIT  5
`define CMP_MODE_FALL_IE_BIT  4
`define CMP_MODE_SRC_IE_BIT   0

// status register bits
`define CMP_STAT_RESULT_BIT 6
`define CMP_STAT_RISE_BIT   5
`define CMP_STAT_FALL_BIT   4

// synchroniser depth
`define CMP_SYNC_STAGES 2

// analog mux widths
`define CMP_POS_MUX_WIDTH 12
`define CMP_NEG_MUX_WIDTH 11

`endif

// File: hdl/comparator_pkg.sv
/*
 * Types of the comparator output and interrupt block: channel codes of
 * both input select fields.
 * Assumes nothing of its surroundings.
 */
package comparator_pkg;

   // negative input channel codes
   typedef enum logic [3:0] {
      NEG_PIN_0   = 4'h0,
      NEG_PIN_1   = 4'h1,
      NEG_PIN_2   = 4'h2,
      NEG_PIN_3   = 4'h3,
      NEG_PIN_4   = 4'h4,
      NEG_PIN_5   = 4'h5,
      NEG_PIN_6   = 4'h6,
      NEG_TOUCH   = 4'hC,
      NEG_HALF    = 4'hD,
      NEG_DIGITAL = 4'hE,
      NEG_GROUND  = 4'hF
   } neg_channel_t;

   // positive input channel codes
   typedef enum logic [3:0] {
      POS_PIN_0   = 4'h0,
      POS_PIN_7   = 4'h7,
      POS_TOUCH   = 4'hC,
      POS_HALF    = 4'hD,
      POS_BATTERY = 4'hE,
      POS_SUPPLY  = 4'hF
   } pos_channel_t;

endpackage
